// ===== logic/ipmc_core.sv
`include "ipmc_regs.svh"
module ipmc_core
  import ipmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Software mode and mask writes
  input wire logic [1:0] mode_in,
  input wire logic mask_wr_in,
  input wire logic glob_mask_in,
  input wire logic user_mask_in,
  input wire logic advanced_in,
  // Instruction boundary
  input wire logic instr_done_in,
  // Current program counter
  input wire logic [`IPMC_ADDR_W-1:0] pc_in,
  // Stack and vector outputs
  output logic stack_we_out,
  output logic [`IPMC_ADDR_W-1:0] stack_pc_out,
  output logic [7:0] stack_cond_out,
  output logic fetch_out,
  output logic [`IPMC_ADDR_W-1:0] vec_addr_out,
  // Controller side
  ipmc_if.core ctrl_if
);
  typedef struct packed {
    ipmc_core_state_t fsm;
    logic glob_mask;
    logic user_mask;
    logic [1:0] mode;
    logic ack;
    logic [`IPMC_VEC_W-1:0] vec;
    logic stack_we;
    logic [`IPMC_ADDR_W-1:0] stack_pc;
    logic [7:0] stack_cond;
    logic fetch;
    logic [`IPMC_ADDR_W-1:0] vec_addr;
  } ipmc_core_rec_t;

  ipmc_core_rec_t st;
  ipmc_core_rec_t next_st;

  // Core exception sequence
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.stack_we = 1'b0;
    next_st.fetch = 1'b0;
    case (st.fsm)
      IPMC_RUN: begin
        next_st.mode = mode_in;
        if (mask_wr_in) begin
          next_st.glob_mask = glob_mask_in;
          next_st.user_mask = user_mask_in;
        end
        if (ctrl_if.req) begin
          next_st.ack = 1'b1;
          next_st.vec = ctrl_if.vec;
          next_st.fsm = IPMC_FINISH;
        end
      end
      IPMC_FINISH: begin
        if (instr_done_in) begin
          next_st.fsm = IPMC_STACK;
        end
      end
      IPMC_STACK: begin
        next_st.stack_we = 1'b1;
        next_st.stack_pc = pc_in;
        next_st.stack_cond = {st.glob_mask, 1'b0, st.user_mask, 5'h00};
        next_st.fsm = IPMC_MASK;
      end
      IPMC_MASK: begin
        next_st.glob_mask = 1'b1;
        if (st.mode[0]) begin
          next_st.user_mask = 1'b1;
        end
        next_st.fsm = IPMC_FETCH;
      end
      IPMC_FETCH: begin
        next_st.fetch = 1'b1;
        next_st.vec_addr = advanced_in ? 16'(st.vec) * `IPMC_ENTRY_ADV
                                       : 16'(st.vec) * `IPMC_ENTRY_NORMAL;
        next_st.fsm = IPMC_RUN;
      end
      default: begin
        next_st.fsm = IPMC_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Reset leaves only the global mask raised
      st <= '{fsm: IPMC_RUN, glob_mask: 1'b1, user_mask: 1'b0, mode: 2'h0, ack: 1'b0,
        vec: 8'h00, stack_we: 1'b0, stack_pc: 16'h0000, stack_cond: 8'h00, fetch: 1'b0,
        vec_addr: 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  assign ctrl_if.ack = st.ack;
  assign ctrl_if.glob_mask = st.glob_mask;
  assign ctrl_if.user_mask_bit = st.user_mask;
  assign ctrl_if.ctrl_mode_bit_hi = st.mode[1];
  assign ctrl_if.ctrl_mode_bit_lo = st.mode[0];
  assign stack_we_out = st.stack_we;
  assign stack_pc_out = st.stack_pc;
  assign stack_cond_out = st.stack_cond;
  assign fetch_out = st.fetch;
  assign vec_addr_out = st.vec_addr;
endmodule : ipmc_core

// ===== logic/ipmc_regs.svh
`ifndef IPMC_REGS_SVH
`define IPMC_REGS_SVH
// Operation
// - Non-maskable request accepted except reset, standby
// - Per-source enable bit gates each request
// - Mode bits select control mode 0 or 1
// - Mode 0: global mask blocks all maskable
// - Level 1 requests win over level 0
// - Same level: fixed default order decides
// - Unselected lower requests stay pending
// - Mode 1: level 0 needs global mask clear
// - Mode 1: level 1 blocked only both masks
// - Exception starts after current instruction completes
// - Core stacks program counter and condition register
// - Mode 0: core sets global mask after stacking
// - Mode 1: core sets both masks after stacking
// - Vector address generated; core jumps through it
// - Level register value 20 raises requests 2,3; here each level bit is one source, so 20 raises source 5 only
// - Vector spacing two bytes normal, four advanced
`define IPMC_NUM_SRC 16
`define IPMC_VEC_W 8
`define IPMC_ADDR_W 16
`define IPMC_NMI_VEC 8'h07
`define IPMC_SRC_VEC_BASE 8'h10
`define IPMC_LVL_RST 16'h0000
`define IPMC_LVL_EXAMPLE 8'h20
`define IPMC_ENTRY_NORMAL 16'h0002
`define IPMC_ENTRY_ADV 16'h0004
`endif

// ===== logic/ipmc_pkg.sv
package ipmc_pkg;
  // Core sequencing states
  typedef enum logic [2:0] {
    IPMC_RUN,
    IPMC_FINISH,
    IPMC_STACK,
    IPMC_MASK,
    IPMC_FETCH
  } ipmc_core_state_t;
endpackage : ipmc_pkg

// ===== logic/ipmc_if.sv
`include "ipmc_regs.svh"
interface ipmc_if;
  // Request flag from controller to core
  logic req;
  // Request is the non-maskable one
  logic req_nmi;
  // Vector number of the selected request
  logic [`IPMC_VEC_W-1:0] vec;
  // Core accepts the presented request
  logic ack;
  // Core mask bits and control mode
  logic glob_mask;
  logic user_mask_bit;
  logic ctrl_mode_bit_hi;
  logic ctrl_mode_bit_lo;
  modport ctrl (output req, output req_nmi, output vec, input ack,
    input glob_mask, input user_mask_bit, input ctrl_mode_bit_hi, input ctrl_mode_bit_lo);
  modport core (input req, input req_nmi, input vec, output ack,
    output glob_mask, output user_mask_bit, output ctrl_mode_bit_hi, output ctrl_mode_bit_lo);
endinterface : ipmc_if

// ===== logic/ipmc_ctrl.sv
`include "ipmc_regs.svh"
module ipmc_ctrl
  import ipmc_pkg::*;
#(
  parameter int NUM_SRC = `IPMC_NUM_SRC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Standby hold
  input wire logic standby_in,
  // Source requests, index 0 ranks highest
  input wire logic nmi_in,
  input wire logic [NUM_SRC-1:0] src_req_in,
  input wire logic [NUM_SRC-1:0] src_enable_in,
  // Per-source control level
  input wire logic [NUM_SRC-1:0] priority_level_reg_in,
  // Core side
  ipmc_if.ctrl core_if
);
  // All state in one record
  typedef struct packed {
    logic nmi_pend; // Non-maskable request latched
    logic req; // Request flag towards the core
    logic req_nmi; // Standing request is the non-maskable one
    logic req_lvl1; // Standing request came from control level 1
    logic [`IPMC_VEC_W-1:0] vec; // Vector number of the standing request
  } ipmc_ctrl_state_t;

  ipmc_ctrl_state_t st;
  ipmc_ctrl_state_t next_st;
  logic [NUM_SRC-1:0] gated;
  logic [NUM_SRC-1:0] lvl1;
  logic [NUM_SRC-1:0] lvl0;
  logic mode1;
  logic allow0;
  logic allow1;

  // Selection and pending update
  always_comb begin
    next_st = st;
    gated = src_req_in & src_enable_in;
    mode1 = core_if.ctrl_mode_bit_lo;
    allow0 = !core_if.glob_mask;
    allow1 = mode1 ? !(core_if.glob_mask && core_if.user_mask_bit) : !core_if.glob_mask;
    lvl1 = gated & priority_level_reg_in & {NUM_SRC{allow1}};
    // Sources are never cleared here, so unselected ones stay pending on their lines
    lvl0 = gated & ~priority_level_reg_in & {NUM_SRC{allow0}};
    if (nmi_in) begin
      next_st.nmi_pend = 1'b1;
    end
    if (core_if.ack && st.req) begin
      // Accepted request leaves the core line
      next_st.req = 1'b0;
      if (st.req_nmi) begin
        next_st.nmi_pend = nmi_in;
      end
    end else if (st.req && !st.req_nmi && !(st.req_lvl1 ? allow1 : allow0)) begin
      // Masks rose while the core was busy: withdraw, else the core would take a masked source later
      next_st.req = 1'b0;
    end else if (!st.req) begin
      // Pick a new request, held until acknowledged or withdrawn by the masks
      if (st.nmi_pend || nmi_in) begin
        next_st.req = 1'b1;
        next_st.req_nmi = 1'b1;
        next_st.req_lvl1 = 1'b0;
        next_st.vec = `IPMC_NMI_VEC;
      end else if (|lvl1) begin
        next_st.req = 1'b1;
        next_st.req_nmi = 1'b0;
        next_st.req_lvl1 = 1'b1;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
          if (lvl1[i]) begin
            next_st.vec = `IPMC_SRC_VEC_BASE + 8'(i);
          end
        end
      end else if (|lvl0) begin
        next_st.req = 1'b1;
        next_st.req_nmi = 1'b0;
        next_st.req_lvl1 = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
          if (lvl0[i]) begin
            next_st.vec = `IPMC_SRC_VEC_BASE + 8'(i);
          end
        end
      end
    end
    if (standby_in) begin
      // Standby discards everything
      next_st = '0;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign core_if.req = st.req;
  assign core_if.req_nmi = st.req_nmi;
  assign core_if.vec = st.vec;
endmodule : ipmc_ctrl

// ===== dv/ipmc_chk.sv
`include "ipmc_regs.svh"
module ipmc_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link between the two ends
  input wire logic req,
  input wire logic req_nmi,
  input wire logic [`IPMC_VEC_W-1:0] vec,
  input wire logic ack,
  input wire logic glob_mask,
  input wire logic user_mask_bit,
  input wire logic ctrl_mode_bit_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Acceptance followed by withdrawal of the flag
  sequence s_done; ack ##1 !req; endsequence
  // A non-maskable request, or one standing with the global mask clear, stays unchanged until taken
  property p_hold; req && !ack && (req_nmi || !glob_mask) |=> req && $stable(vec); endproperty
  a_hold: assert property (p_hold) else $error("request moved before ack");
  property p_drop; ack |-> s_done; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_ack; ack |-> $past(req) ##1 !ack; endproperty
  a_ack: assert property (p_ack) else $error("ack without request");
  property p_nmi; req && req_nmi |-> vec == `IPMC_NMI_VEC; endproperty
  a_nmi: assert property (p_nmi) else $error("wrong nmi vector");
  property p_src; req && !req_nmi |-> vec >= `IPMC_SRC_VEC_BASE && vec < 8'h20; endproperty
  a_src: assert property (p_src) else $error("source vector out of range");
  property p_m0; $rose(req) && !req_nmi && !ctrl_mode_bit_lo |-> !$past(glob_mask); endproperty
  a_m0: assert property (p_m0) else $error("masked request raised");
  property p_m1; $rose(req) && !req_nmi && ctrl_mode_bit_lo |-> !($past(glob_mask) && $past(user_mask_bit));
  endproperty
  a_m1: assert property (p_m1) else $error("fully masked request raised");
  property p_rst; $fell(rst_in) |-> !req && !ack && glob_mask; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // A maskable request that every mask now blocks leaves the core line
  property p_wdraw; req && !req_nmi && glob_mask && (!ctrl_mode_bit_lo || user_mask_bit) |=> !req; endproperty
  a_wdraw: assert property (p_wdraw) else $error("masked request kept");
endmodule : ipmc_chk

// ===== dv/interrupt_priority_mask_ctrl_tb.sv
module interrupt_priority_mask_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Driven inputs
  logic clk_in = 0, rst_in = 1, nmi = 0, mask_wr = 0, gm = 0, um = 0, adv = 0, done = 0, stby = 0;
  logic [15:0] src_req = '0, src_en = '0, lvl = '0;
  logic [1:0] mode = '0;
  // Observed outputs
  logic fetch, stack_we;
  logic [7:0] stack_cond;
  logic [15:0] stack_pc, vec_addr;
  int err_count = 0, checked = 0;
  ipmc_if ifc();
  ipmc_ctrl i_ipmc_ctrl (.clk_in, .rst_in, .standby_in(stby), .nmi_in(nmi), .src_req_in(src_req),
    .src_enable_in(src_en), .priority_level_reg_in(lvl), .core_if(ifc));
  ipmc_core i_ipmc_core (.clk_in, .rst_in, .mode_in(mode), .mask_wr_in(mask_wr), .glob_mask_in(gm),
    .user_mask_in(um), .advanced_in(adv), .instr_done_in(done), .pc_in(16'h1234), .stack_we_out(stack_we),
    .stack_pc_out(stack_pc), .stack_cond_out(stack_cond), .fetch_out(fetch), .vec_addr_out(vec_addr),
    .ctrl_if(ifc));
  ipmc_chk i_ipmc_chk (.clk_in, .rst_in, .req(ifc.req), .req_nmi(ifc.req_nmi), .vec(ifc.vec), .ack(ifc.ack),
    .glob_mask(ifc.glob_mask), .user_mask_bit(ifc.user_mask_bit), .ctrl_mode_bit_lo(ifc.ctrl_mode_bit_lo));
  // Free running clock
  initial forever #4 clk_in = ~clk_in;
  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // Report and stop
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Software write of both mask bits
  task automatic masks(input logic g, input logic u);
    gm <= g;
    um <= u;
    mask_wr <= 1'b1;
    @(posedge clk_in);
    mask_wr <= 1'b0;
    @(posedge clk_in);
  endtask : masks
  // No request may appear
  task automatic quiet;
    repeat (5) @(negedge clk_in);
    chk("req", 16'h0000, {15'h0000, ifc.req});
    @(posedge clk_in);
  endtask : quiet
  // Full acceptance: vector, wait for the instruction, stacking, vector address; left stays on the sources
  task automatic serve(input logic [7:0] v, input logic [15:0] a, input logic [7:0] c, input logic [15:0] left);
    int n;
    logic seen;
    for (n = 0; n < 20 && ifc.req !== 1'b1; n++) @(negedge clk_in);
    chk("req", 16'h0001, {15'h0000, ifc.req});
    chk("vec", {8'h00, v}, {8'h00, ifc.vec});
    @(posedge clk_in);
    src_req <= left;
    nmi <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      @(negedge clk_in);
      seen = seen | stack_we;
    end
    chk("early", 16'h0000, {15'h0000, seen});
    @(posedge clk_in);
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
    for (n = 0; n < 20 && fetch !== 1'b1; n++) begin
      @(negedge clk_in);
      seen = seen | stack_we;
    end
    chk("fetch", 16'h0001, {15'h0000, fetch});
    chk("stack", 16'h0001, {15'h0000, seen});
    chk("addr", a, vec_addr);
    chk("pc", 16'h1234, stack_pc);
    chk("cond", {8'h00, c}, {8'h00, stack_cond});
    @(posedge clk_in);
  endtask : serve
  // Mode 0: level order, default order, enable gating, a source left raised stays masked
  task automatic t_mode0;
    src_en <= 16'h000D;
    lvl <= 16'h000C;
    src_req <= 16'h000F;
    quiet();
    masks(1'b0, 1'b0);
    serve(8'h12, 16'h0024, 8'h00, 16'h0001);
    chk("gmask", 16'h0001, {15'h0000, ifc.glob_mask});
    quiet();
    src_req <= 16'h0002;
    masks(1'b0, 1'b0);
    quiet();
  endtask : t_mode0
  // Mode 1: three level masking in advanced addressing
  task automatic t_mode1;
    mode <= 2'b01;
    adv <= 1'b1;
    masks(1'b1, 1'b0);
    src_req <= 16'h0009;
    serve(8'h13, 16'h004C, 8'h80, 16'h0000);
    chk("masks", 16'h0003, {14'h0000, ifc.glob_mask, ifc.user_mask_bit});
    src_req <= 16'h0001;
    masks(1'b1, 1'b0);
    quiet();
    masks(1'b0, 1'b1);
    serve(8'h10, 16'h0040, 8'h20, 16'h0000);
  endtask : t_mode1
  // Non-maskable request with every mask set
  task automatic t_nmi;
    mode <= 2'b11;
    masks(1'b1, 1'b1);
    nmi <= 1'b1;
    serve(8'h07, 16'h001C, 8'hA0, 16'h0000);
  endtask : t_nmi
  // Standby drops the non-maskable request; a reset in mid-run restores the masks
  task automatic t_standby;
    stby <= 1'b1;
    nmi <= 1'b1;
    quiet();
    stby <= 1'b0;
    serve(8'h07, 16'h001C, 8'hA0, 16'h0000);
    rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk("rmask", 16'h0002, {14'h0000, ifc.glob_mask, ifc.user_mask_bit});
    chk("rreq", 16'h0000, {15'h0000, ifc.req});
    @(posedge clk_in);
  endtask : t_standby
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_mode0();
    t_mode1();
    t_nmi();
    t_standby();
    finish_test();
  end
  // Watchdog
  initial begin
    #50us;
    err_count++;
    finish_test();
  end
endmodule : interrupt_priority_mask_ctrl_tb
